// file: wtg_pkg.sv
// Constants, register map and field layout of the window timeout guard.
// Assumes one 40 MHz clock; the CPU reaches the registers over AXI4-Lite.
package wtg_pkg;

  // ************************************************************
  // Bus and register map
  // ************************************************************
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int IDX_W = 10;
  // Register indices; the byte address is four times the index
  localparam logic [IDX_W-1:0] CTRL_IDX = 10'h02a;
  localparam logic [IDX_W-1:0] WIN_IDX = 10'h02b;
  localparam logic [IDX_W-1:0] OPT_IDX = 10'h02c;
  localparam logic [IDX_W-1:0] STAT_IDX = 10'h02d;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ************************************************************
  // Fields and reset values
  // ************************************************************
  localparam int CNT_W = 7;
  localparam int ACT_BIT = 7;
  localparam int TOP_BIT = 6;
  localparam int OPT_HW_BIT = 0;
  localparam int OPT_STOP_BIT = 1;
  localparam int STAT_ACT_BIT = 0;
  localparam int STAT_PULSE_BIT = 1;
  localparam logic [CNT_W-1:0] CNT_RST = 7'h7f;
  localparam logic [CNT_W-1:0] WIN_RST = 7'h7f;
  localparam logic [CNT_W-1:0] ROLL_FROM = 7'h40;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_MHZ = 40;
  localparam int PRESC_W = 14;
  localparam int PRESC_DEFAULT = 16384;
  localparam int RST_PULSE_US = 30;
  localparam int PULSE_W = 11;
  localparam logic [PULSE_W-1:0] RST_PULSE_CYC = PULSE_W'(RST_PULSE_US * CLK_MHZ);

endpackage

// file: wtg_tick_if.sv
// Carries the prescaler step enable from the prescaler to the guard core.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface wtg_tick_if;
  logic tick;
  modport src (output tick);
  modport snk (input tick);
endinterface
`default_nettype wire

// file: wtg_prescaler.sv
// Free-running prescaler: one-cycle step enable every PRESC_CYCLES clocks.
// Assumes a synchronous active-low reset; nothing else restarts it.
`timescale 1ns/1ps
`default_nettype none
module wtg_prescaler #(
  parameter int PRESC_CYCLES = wtg_pkg::PRESC_DEFAULT
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  wtg_tick_if.src tick_if
);
  import wtg_pkg::*;

  typedef struct packed {
    logic [PRESC_W-1:0] cnt;
    logic tick;
  } wtg_presc_st_t;

  localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(PRESC_CYCLES - 1);

  wtg_presc_st_t st_reg;
  wtg_presc_st_t st_next;

  // Never cleared by a counter write, so the first step after a refresh
  // lands anywhere inside the period
  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (st_reg.cnt == PRESC_LAST) begin
      st_next.cnt = '0;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick_if.tick = st_reg.tick;

endmodule
`default_nettype wire

// file: wtg_top.sv
// Window timeout guard: 7-bit downcounter, window check, reset pulse.
// Assumes an AXI4-Lite master on clk_i and a stop strobe from the CPU core.
//
// How it works
// - Counter steps down once per 16384 clocks.
// - Active guard resets on 40h to 3Fh.
// - Reset pin held low about 30 us.
// - Refresh above window value while active resets.
// - Activation bit set by software, cleared by reset.
// - Hardware option keeps guard always active.
// - Counter runs freely even while guard disabled.
// - Writing top bit clear while active resets.
// - Stop instruction resets when option selected and guard active.
// - Low six bits give 64 timeout steps.
// - Counter writes never restart the prescaler.
// - Window register holds refresh upper limit.
// - Control resets to 7Fh, activation bit sticky.
// - Window register 7 bits, resets to 7Fh.
`timescale 1ns/1ps
`default_nettype none
module wtg_top #(
  parameter int PRESC_CYCLES = wtg_pkg::PRESC_DEFAULT
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [wtg_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [wtg_pkg::DATA_W-1:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [wtg_pkg::ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [wtg_pkg::DATA_W-1:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic stop_exec_i,
  output logic wd_rst_n_o
);
  import wtg_pkg::*;

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic guard_activate_bit;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] guard_window_reg;
    logic opt_hw;
    logic reset_on_stop_option;
    logic [PULSE_W-1:0] pulse;
    logic rst_low;
    logic aw_seen;
    logic [ADDR_W-1:0] awaddr;
    logic w_seen;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } wtg_state_t;

  wtg_state_t st_reg;
  wtg_state_t st_next;

  wtg_tick_if tick_if ();

  wtg_prescaler #(
    .PRESC_CYCLES(PRESC_CYCLES)
  ) u_presc (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .tick_if(tick_if)
  );

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [IDX_W-1:0] idx);
    hit = (addr[ADDR_W-1:2] == idx);
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] addr);
    mapped = hit(addr, CTRL_IDX) | hit(addr, WIN_IDX) | hit(addr, OPT_IDX)
           | hit(addr, STAT_IDX);
  endfunction

  logic active;
  logic ar_take;
  logic wr_fire;
  logic wr_ctrl;
  logic wr_win;
  logic wr_opt;
  logic new_act;
  logic trig_roll;
  logic trig_early;
  logic trig_soft;
  logic trig_stop;
  logic trig_any;

  assign active = st_reg.guard_activate_bit | st_reg.opt_hw;
  assign s_axi_awready_o = !st_reg.aw_seen && !st_reg.bvalid;
  assign s_axi_wready_o = !st_reg.w_seen && !st_reg.bvalid;
  assign s_axi_arready_o = !st_reg.rvalid;
  assign ar_take = s_axi_arvalid_i && s_axi_arready_o;
  assign wr_fire = st_reg.aw_seen && st_reg.w_seen && !st_reg.bvalid;
  assign wr_ctrl = wr_fire && st_reg.wstrb0 && hit(st_reg.awaddr, CTRL_IDX);
  assign wr_win = wr_fire && st_reg.wstrb0 && hit(st_reg.awaddr, WIN_IDX);
  assign wr_opt = wr_fire && st_reg.wstrb0 && hit(st_reg.awaddr, OPT_IDX);

  // ************************************************************
  // Reset causes
  // ************************************************************
  // A control write in the same cycle as a step replaces the step, so no rollover
  assign trig_roll = tick_if.tick && active && !wr_ctrl && (st_reg.cnt == ROLL_FROM);
  // Compare uses the count before the write lands
  assign trig_early = wr_ctrl && active && (st_reg.cnt > st_reg.guard_window_reg);
  assign new_act = active | st_reg.wdata[ACT_BIT];
  assign trig_soft = wr_ctrl && new_act && !st_reg.wdata[TOP_BIT];
  assign trig_stop = stop_exec_i && active && st_reg.reset_on_stop_option;
  assign trig_any = trig_roll | trig_early | trig_soft | trig_stop;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    st_next = st_reg;
    // Counter: loaded by a refresh, otherwise steps down and wraps
    if (wr_ctrl) begin
      st_next.cnt = st_reg.wdata[CNT_W-1:0];
      if (st_reg.wdata[ACT_BIT]) begin
        st_next.guard_activate_bit = 1'b1;
      end
    end else if (tick_if.tick) begin
      st_next.cnt = st_reg.cnt - 1'b1;
    end
    if (wr_win) begin
      st_next.guard_window_reg = st_reg.wdata[CNT_W-1:0];
    end
    if (wr_opt) begin
      st_next.opt_hw = st_reg.wdata[OPT_HW_BIT];
      st_next.reset_on_stop_option = st_reg.wdata[OPT_STOP_BIT];
    end
    // Reset pulse; causes arriving mid-pulse are absorbed by it
    if (st_reg.pulse != '0) begin
      st_next.pulse = st_reg.pulse - 1'b1;
    end else if (trig_any) begin
      st_next.pulse = RST_PULSE_CYC;
    end
    st_next.rst_low = (st_next.pulse != '0);
    // Write channel: address and data in either order
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      st_next.aw_seen = 1'b1;
      st_next.awaddr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      st_next.w_seen = 1'b1;
      st_next.wdata = s_axi_wdata_i[7:0];
      st_next.wstrb0 = s_axi_wstrb_i[0];
    end
    if (wr_fire) begin
      st_next.aw_seen = 1'b0;
      st_next.w_seen = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = mapped(st_reg.awaddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (st_reg.bvalid && s_axi_bready_i) begin
      st_next.bvalid = 1'b0;
    end
    // Read channel
    if (ar_take) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
      st_next.rdata = '0;
      if (hit(s_axi_araddr_i, CTRL_IDX)) begin
        st_next.rdata = {st_reg.guard_activate_bit, st_reg.cnt};
      end else if (hit(s_axi_araddr_i, WIN_IDX)) begin
        st_next.rdata = {1'b0, st_reg.guard_window_reg};
      end else if (hit(s_axi_araddr_i, OPT_IDX)) begin
        st_next.rdata[OPT_HW_BIT] = st_reg.opt_hw;
        st_next.rdata[OPT_STOP_BIT] = st_reg.reset_on_stop_option;
      end else if (hit(s_axi_araddr_i, STAT_IDX)) begin
        st_next.rdata[STAT_ACT_BIT] = active;
        st_next.rdata[STAT_PULSE_BIT] = st_reg.rst_low;
      end
    end else if (st_reg.rvalid && s_axi_rready_i) begin
      st_next.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
      st_reg.cnt <= CNT_RST;
      st_reg.guard_window_reg <= WIN_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign wd_rst_n_o = !st_reg.rst_low;
  assign s_axi_bvalid_o = st_reg.bvalid;
  assign s_axi_bresp_o = st_reg.bresp;
  assign s_axi_rvalid_o = st_reg.rvalid;
  assign s_axi_rresp_o = st_reg.rresp;
  assign s_axi_rdata_o = {{(DATA_W - 8){1'b0}}, st_reg.rdata};

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  logic [PULSE_W-1:0] low_len;
  logic idle;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      low_len <= '0;
    end else if (!wd_rst_n_o) begin
      low_len <= low_len + 1'b1;
    end else begin
      low_len <= '0;
    end
  end

  assign idle = wd_rst_n_o && (st_reg.pulse == '0);

  a_count_step: assert property (tick_if.tick && !wr_ctrl |=> st_reg.cnt == $past(st_reg.cnt) - 7'h01)
    else $error("counter did not step on prescaler tick");
  a_free_running: assert property (!active && tick_if.tick && !wr_ctrl ##1 !active |-> st_reg.cnt != $past(st_reg.cnt))
    else $error("counter stalled while guard disabled");
  a_roll_reset: assert property (idle && active && tick_if.tick && !wr_ctrl && st_reg.cnt == ROLL_FROM |=> !wd_rst_n_o)
    else $error("rollover to 3Fh gave no reset");
  // The counter has already taken in the last low cycle when the pin rises
  a_pulse_width: assert property ($rose(wd_rst_n_o) |-> low_len == RST_PULSE_CYC)
    else $error("reset pulse has wrong length");
  a_early_refresh: assert property (idle && wr_ctrl && active && st_reg.cnt > st_reg.guard_window_reg |=> !wd_rst_n_o)
    else $error("refresh above window gave no reset");
  a_in_window_ok: assert property (idle && wr_ctrl && st_reg.cnt <= st_reg.guard_window_reg && st_reg.wdata[6] && !tick_if.tick && !stop_exec_i |=> wd_rst_n_o)
    else $error("refresh inside window caused reset");
  a_act_sticky: assert property (st_reg.guard_activate_bit |=> st_reg.guard_activate_bit)
    else $error("activation bit cleared without reset");
  a_hw_forces: assert property (st_reg.opt_hw && !st_reg.guard_activate_bit && wr_ctrl && !st_reg.wdata[6] && idle |=> !wd_rst_n_o)
    else $error("hardware option did not force activation");
  a_soft_reset: assert property (idle && wr_ctrl && (active || st_reg.wdata[7]) && !st_reg.wdata[6] |=> !wd_rst_n_o)
    else $error("software reset not generated");
  a_stop_reset: assert property (idle && stop_exec_i && active && st_reg.reset_on_stop_option |=> !wd_rst_n_o)
    else $error("stop instruction gave no reset");
  a_window_store: assert property (wr_win |=> st_reg.guard_window_reg == $past(st_reg.wdata[6:0]))
    else $error("window register not updated");
  a_no_cause: assert property ($fell(wd_rst_n_o) |-> $past(trig_any))
    else $error("reset pulse without cause");

  c_roll: cover property (trig_roll && idle);
  c_early: cover property (trig_early && idle);
  c_soft: cover property (trig_soft && idle);
  c_stop: cover property (trig_stop && idle);

endmodule
`default_nettype wire

// file: wtg_cpu_model.sv
// AXI4-Lite master standing in for the CPU software that reaches the guard.
// Assumes the bench calls its tasks one at a time; signals change by NBA after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module wtg_cpu_model (
  input wire logic clk_i,
  output logic [11:0] awaddr_o,
  output logic awvalid_o,
  input wire logic awready_i,
  output logic [31:0] wdata_o,
  output logic [3:0] wstrb_o,
  output logic wvalid_o,
  input wire logic wready_i,
  input wire logic [1:0] bresp_i,
  input wire logic bvalid_i,
  output logic bready_o,
  output logic [11:0] araddr_o,
  output logic arvalid_o,
  input wire logic arready_i,
  input wire logic [31:0] rdata_i,
  input wire logic [1:0] rresp_i,
  input wire logic rvalid_i,
  output logic rready_o
);
  initial {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, bready_o} = '0;
  initial {araddr_o, arvalid_o, rready_o} = '0;

  // Address and data are offered together and each is released when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    logic aw_d;
    logic w_d;
    aw_d = 1'b0;
    w_d = 1'b0;
    @(posedge clk_i);
    awaddr_o <= a;
    wdata_o <= d;
    wstrb_o <= s;
    awvalid_o <= 1'b1;
    wvalid_o <= 1'b1;
    bready_o <= 1'b1;
    while (!(aw_d && w_d)) begin
      @(posedge clk_i);
      if (!aw_d && awready_i === 1'b1) begin
        aw_d = 1'b1;
        awvalid_o <= 1'b0;
      end
      if (!w_d && wready_i === 1'b1) begin
        w_d = 1'b1;
        wvalid_o <= 1'b0;
      end
    end
    do @(posedge clk_i); while (bvalid_i !== 1'b1);
    r = bresp_i;
    bready_o <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_i);
    araddr_o <= a;
    arvalid_o <= 1'b1;
    rready_o <= 1'b1;
    do @(posedge clk_i); while (arready_i !== 1'b1);
    arvalid_o <= 1'b0;
    while (rvalid_i !== 1'b1) @(posedge clk_i);
    d = rdata_i;
    r = rresp_i;
    rready_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: tb.sv
// Self-checking bench for the window timeout guard, short prescaler.
// Assumes the CPU model drives the register bus; the bench owns reset and stop.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import wtg_pkg::*;
  localparam int P = 16;
  logic clk_i, rst_n, stop, wd_n, awv, awr, wv, wr_rdy, bv, br, arv, arr, rv, rr;
  logic [11:0] awa, ara;
  logic [31:0] wd, rdat, v;
  logic [3:0] ws;
  logic [1:0] bresp, rresp, r;
  int fails, n_checks, cyc, npulse, lowcnt, fall_cyc, plen, t0, n0;

  wtg_top #(.PRESC_CYCLES(P)) wtg_top_inst (.clk_i(clk_i), .rst_n_i(rst_n),
    .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
    .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_rdy),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(br),
    .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_rdata_o(rdat), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(rr),
    .stop_exec_i(stop), .wd_rst_n_o(wd_n));
  wtg_cpu_model wtg_cpu_model_inst (.clk_i(clk_i), .awaddr_o(awa), .awvalid_o(awv),
    .awready_i(awr), .wdata_o(wd), .wstrb_o(ws), .wvalid_o(wv), .wready_i(wr_rdy),
    .bresp_i(bresp), .bvalid_i(bv), .bready_o(br), .araddr_o(ara), .arvalid_o(arv),
    .arready_i(arr), .rdata_i(rdat), .rresp_i(rresp), .rvalid_i(rv), .rready_o(rr));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  initial {rst_n, stop, cyc, npulse, lowcnt, fall_cyc, plen, fails, n_checks} = '0;

  // ************************************************************
  // Pulse monitor: NBA so every reader sees pre-edge values
  // ************************************************************
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (wd_n === 1'b0) begin
      lowcnt <= lowcnt + 1;
      if (lowcnt == 0) fall_cyc <= cyc;
    end else if (lowcnt != 0) begin
      plen <= lowcnt;
      npulse <= npulse + 1;
      lowcnt <= 0;
    end
  end

  function automatic logic [11:0] ba(input logic [IDX_W-1:0] i);
    return {i, 2'b00};
  endfunction
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_range(input int got, input int lo, input int hi);
    n_checks++;
    if (got < lo || got > hi) begin
      fails++;
      $display("BAD t=%0t value %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask
  task automatic do_reset();
    @(posedge clk_i);
    rst_n <= 1'b0;
    repeat (20) @(posedge clk_i);
    rst_n <= 1'b1;
  endtask
  // Pulse must start lo..hi cycles after t0; the bench then resets the guard itself with do_reset
  task automatic expect_pulse(input int lo, input int hi);
    while (npulse == n0) @(posedge clk_i);
    chk_range(fall_cyc - t0, lo, hi);
    chk_val(32'(plen), 32'(RST_PULSE_CYC));
    do_reset();
  endtask
  task automatic wrc(input logic [IDX_W-1:0] i, input logic [7:0] d);
    wtg_cpu_model_inst.wr(ba(i), {24'h0, d}, 4'h1, r);
  endtask
  task automatic pulse_stop();
    @(posedge clk_i);
    stop <= 1'b1;
    @(posedge clk_i);
    stop <= 1'b0;
  endtask
  task automatic mark();
    n0 = npulse;
    t0 = cyc;
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset_vals();
    wtg_cpu_model_inst.rd(ba(CTRL_IDX), v, r);
    chk_val(v, 32'h7f);
    wtg_cpu_model_inst.rd(ba(WIN_IDX), v, r);
    chk_val(v, 32'h7f);
    wtg_cpu_model_inst.rd(12'h000, v, r);
    chk_val({v[29:0], r}, {30'h0, RESP_SLVERR});
    wtg_cpu_model_inst.wr(12'h000, 32'h0, 4'h1, r);
    chk_val(32'(r), 32'(RESP_SLVERR));
  endtask
  task automatic t_free_run();
    logic [31:0] v1;
    mark();
    wtg_cpu_model_inst.rd(ba(CTRL_IDX), v1, r);
    repeat (4 * P) @(posedge clk_i);
    wtg_cpu_model_inst.rd(ba(CTRL_IDX), v, r);
    chk_range(int'((v1[6:0] - v[6:0]) & 7'h7f), 4, 5);
    repeat (130 * P) @(posedge clk_i);
    chk_val(32'(npulse), 32'(n0));
  endtask
  task automatic t_timeout();
    mark();
    wrc(CTRL_IDX, 8'hc3);
    chk_val(32'(r), 32'(RESP_OKAY));
    expect_pulse(3 * P, 4 * P + 8);
    wtg_cpu_model_inst.rd(ba(STAT_IDX), v, r);
    chk_val(v, 32'h0);
  endtask
  task automatic t_early();
    wrc(CTRL_IDX, 8'hff);
    wrc(WIN_IDX, 8'h50);
    mark();
    wrc(CTRL_IDX, 8'hff);
    wtg_cpu_model_inst.rd(ba(STAT_IDX), v, r);
    chk_val(v, 32'h3);
    expect_pulse(0, 8);
  endtask
  task automatic t_swreset();
    wrc(CTRL_IDX, 8'hff);
    repeat (2 * P) @(posedge clk_i);
    mark();
    wrc(CTRL_IDX, 8'hff);
    wtg_cpu_model_inst.wr(ba(CTRL_IDX), 32'h0, 4'h0, r);
    repeat (8) @(posedge clk_i);
    chk_val(32'(npulse), 32'(n0));
    mark();
    wrc(CTRL_IDX, 8'h3f);
    expect_pulse(0, 8);
  endtask
  task automatic t_stop();
    wrc(OPT_IDX, 8'h02);
    mark();
    pulse_stop();
    repeat (8) @(posedge clk_i);
    chk_val(32'(npulse), 32'(n0));
    wrc(CTRL_IDX, 8'hff);
    mark();
    pulse_stop();
    expect_pulse(0, 4);
  endtask
  task automatic t_hw();
    wrc(OPT_IDX, 8'h01);
    wtg_cpu_model_inst.rd(ba(STAT_IDX), v, r);
    chk_val(v, 32'h1);
    wtg_cpu_model_inst.rd(ba(OPT_IDX), v, r);
    chk_val(v, 32'h1);
    mark();
    wrc(CTRL_IDX, 8'h3f);
    expect_pulse(0, 8);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    // Budget covers five reset pulses and the long free-run wait with margin
    #(40000 * 25);
    fails++;
    end_sim();
  end
  initial begin
    do_reset();
    t_reset_vals();
    t_free_run();
    t_timeout();
    t_early();
    t_swreset();
    t_stop();
    t_hw();
    end_sim();
  end
endmodule
`default_nettype wire
